// [common/laswc_pkg.sv]
// constants and types for the lane alignment and data switch control block
// Function
// - positive alignment character, bits 9:0, reset 283h
// - negative alignment character, bits 9:0, reset 17Ch
// - character register bits 15:10 always read zero
// - bit 6 set stops pll lock check
// - bit 5 set skips signal loss check
// - bit 4 stops sync check; needed for prbs
// - bit 3 flat-lines recovered clock on loss while recovered_clock_output_is_recovered_i is set
// - on pattern match in kx/10g mode
// - off pattern match in kx/10g mode
// - 10g mode stuffs switch output with fill
// - direct clause 45 or indirect clause 22 access
package laswc_pkg;
   // register offsets
   localparam logic [15:0] REG_ALIGN_POS  = 16'h8003;
   localparam logic [15:0] REG_ALIGN_NEG  = 16'h8004;
   localparam logic [15:0] REG_AUTO_CTRL  = 16'h8021;
   localparam logic [15:0] REG_SW_ON      = 16'h802A;
   localparam logic [15:0] REG_SW_OFF     = 16'h802B;
   localparam logic [15:0] REG_SW_FILL    = 16'h802C;
   // reset values
   localparam logic [9:0]  RST_ALIGN_POS  = 10'h283;
   localparam logic [9:0]  RST_ALIGN_NEG  = 10'h17C;
   localparam logic [6:0]  RST_AUTO_CTRL  = 7'h0F;
   localparam logic [9:0]  RST_SW_ON      = 10'h2FD;
   localparam logic [9:0]  RST_SW_OFF     = 10'h2FD;
   localparam logic [9:0]  RST_SW_FILL    = 10'h207;
   localparam logic [15:0] RST_EXT_ADDR   = 16'h0000;
   // auto control field positions
   localparam int          BIT_PLL_OFF    = 6;
   localparam int          BIT_LOSS_OFF   = 5;
   localparam int          BIT_SYNC_OFF   = 4;
   localparam int          BIT_SQUELCH    = 3;
   localparam int          CHAR_W         = 10;
   localparam int          FIFO_DEPTH     = 8;
   // management frame layout
   localparam logic [4:0]  MMD_DEVAD      = 5'h1E;
   localparam logic [4:0]  C22_EXT_ADDR   = 5'h1E;
   localparam logic [4:0]  C22_EXT_DATA   = 5'h1F;
   localparam logic [5:0]  PREAMBLE_ONES  = 6'h20;
   localparam logic [5:0]  HDR_LAST       = 6'h0D;
   localparam logic [5:0]  TA_LAST        = 6'h01;
   localparam logic [5:0]  DATA_LAST      = 6'h0F;
   localparam logic [1:0]  ST_C45         = 2'h0;
   localparam logic [1:0]  ST_C22         = 2'h1;
   localparam logic [1:0]  OP_C45_ADDR    = 2'h0;
   localparam logic [1:0]  OP_C45_WRITE   = 2'h1;
   localparam logic [1:0]  OP_C45_RDINC   = 2'h2;
   localparam logic [1:0]  OP_C22_WRITE   = 2'h1;
   localparam logic [1:0]  OP_C22_READ    = 2'h2;

   typedef enum logic [1:0] {
      LASWC_MODE_10G     = 2'h0,
      LASWC_MODE_1GKX    = 2'h1,
      LASWC_MODE_GENERAL = 2'h2
   } laswc_mode_t;

   typedef enum logic [3:0] {
      MS_IDLE = 4'h1,
      MS_HDR  = 4'h2,
      MS_TA   = 4'h4,
      MS_DATA = 4'h8
   } laswc_mdio_state_t;

   typedef struct packed {
      logic [1:0] st;
      logic [1:0] op;
      logic [4:0] port;
      logic [4:0] dev;
   } laswc_hdr_t;

   typedef struct packed {
      logic pll_locked;
      logic signal_loss;
      logic sync_ok;
   } laswc_health_t;
endpackage : laswc_pkg

// [core/laswc_core.sv]
// management registers, link health checks, lane alignment and tx data switch
`timescale 1ns/1ps
module laswc_core
   import laswc_pkg::*;
(
   // clock and reset
   input  wire logic          mclk_i,
   input  wire logic          resetn_i,
   // management serial port
   input  wire logic          mdc_i,
   input  wire logic          mdio_i,
   output logic               mdio_o,
   output logic               mdio_oe_n_o,
   input  wire logic [4:0]    prtad_i,
   // operating mode
   input  wire laswc_mode_t   mode_i,
   // receive alignment
   input  wire logic          rx_valid_i,
   input  wire logic [9:0]    rx_char_i,
   output logic               align_pos_hit_o,
   output logic               align_neg_hit_o,
   // link health
   input  wire laswc_health_t health_i,
   output logic               pll_lock_fault_o,
   output logic               signal_loss_fault_o,
   output logic               sync_fault_o,
   // clock output
   input  wire logic          recovered_clock_i,
   input  wire logic          recovered_clock_output_is_recovered_i,
   output logic               recovered_clock_output_o,
   // transmit character stream
   input  wire logic          tx_valid_i,
   input  wire logic [9:0]    tx_char_i,
   output logic               tx_ready_o,
   output logic               tx_valid_o,
   output logic [9:0]         tx_char_o,
   input  wire logic          tx_ready_i,
   output logic               tx_switch_off_o
);
   // configuration storage
   logic [9:0]        align_pos_reg;
   logic [9:0]        align_neg_reg;
   logic [6:0]        auto_ctrl_reg;
   logic [9:0]        sw_on_reg;
   logic [9:0]        sw_off_reg;
   logic [9:0]        sw_fill_reg;
   logic [15:0]       ext_addr_reg;
   logic [15:0]       addr_reg;
   // management frame engine
   laswc_mdio_state_t state_reg;
   logic              mdc_q_reg;
   logic [5:0]        cnt_reg;
   logic [15:0]       sh_reg;
   laswc_hdr_t        hdr_reg;
   logic              drv_reg;
   logic              oe_n_reg;
   // data path
   logic              off_state_reg;
   logic              tx_valid_reg;
   logic [9:0]        tx_char_reg;
   logic              f_valid;
   logic [9:0]        f_data;
   logic              pos_hit_reg;
   logic              neg_hit_reg;
   logic              pll_fault_reg;
   logic              loss_fault_reg;
   logic              sync_fault_reg;
   logic              clk_out_reg;

   function automatic logic [15:0] reg_read(input logic [15:0] a);
      logic [15:0] r;
      r = 16'h0000;
      if (a == REG_ALIGN_POS) begin
         r = {6'h00, align_pos_reg};
      end else if (a == REG_ALIGN_NEG) begin
         r = {6'h00, align_neg_reg};
      end else if (a == REG_AUTO_CTRL) begin
         r = {9'h000, auto_ctrl_reg};
      end else if (a == REG_SW_ON) begin
         r = {6'h00, sw_on_reg};
      end else if (a == REG_SW_OFF) begin
         r = {6'h00, sw_off_reg};
      end else if (a == REG_SW_FILL) begin
         r = {6'h00, sw_fill_reg};
      end
      return r;
   endfunction : reg_read

   // frame decode
   wire        mdc_rise  = mdc_i & ~mdc_q_reg;
   wire [13:0] hdr_in    = {sh_reg[12:0], mdio_i};
   wire [15:0] wdata     = {sh_reg[14:0], mdio_i};
   wire        is_c45    = hdr_reg.st == ST_C45;
   wire        is_c22    = hdr_reg.st == ST_C22;
   wire        c22_ptr   = is_c22 && hdr_reg.dev == C22_EXT_ADDR;
   wire        c22_data  = is_c22 && hdr_reg.dev == C22_EXT_DATA;
   wire        hit       = hdr_reg.port == prtad_i
                           && ((is_c45 && hdr_reg.dev == MMD_DEVAD) || c22_ptr || c22_data);
   wire        is_rd     = is_c45 ? hdr_reg.op[1] : hdr_reg.op == OP_C22_READ;
   wire        is_wr     = is_c45 ? hdr_reg.op == OP_C45_WRITE : hdr_reg.op == OP_C22_WRITE;
   wire        drive_rd  = hit & is_rd;
   wire [15:0] acc_addr  = is_c45 ? addr_reg : ext_addr_reg;
   logic [15:0] rd_word;
   wire        data_end  = state_reg == MS_DATA && mdc_rise && cnt_reg == DATA_LAST;
   wire        wr_cfg    = data_end && hit && is_wr && !c22_ptr;
   wire        wr_ptr    = data_end && hit && is_wr && c22_ptr;
   wire        wr_addr   = data_end && hit && is_c45 && hdr_reg.op == OP_C45_ADDR;
   wire        rd_inc    = data_end && hit && is_c45 && hdr_reg.op == OP_C45_RDINC;

   // a process, so that a register written under an unchanged address is read fresh
   always_comb begin
      rd_word = c22_ptr ? ext_addr_reg : reg_read(acc_addr);
   end

   assign mdio_o      = drv_reg;
   assign mdio_oe_n_o = oe_n_reg;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mdc_q_reg <= 1'b0;
         state_reg <= MS_IDLE;
         cnt_reg   <= 6'h00;
         sh_reg    <= 16'h0000;
         hdr_reg   <= '0;
         drv_reg   <= 1'b1;
         oe_n_reg  <= 1'b1;
      end else begin
         mdc_q_reg <= mdc_i;
         if (mdc_rise) begin
            case (state_reg)
               MS_IDLE: begin
                  if (mdio_i) begin
                     if (cnt_reg != PREAMBLE_ONES) begin
                        cnt_reg <= cnt_reg + 6'h01;
                     end
                  end else if (cnt_reg == PREAMBLE_ONES) begin
                     state_reg <= MS_HDR;
                     sh_reg    <= 16'h0000;
                     cnt_reg   <= 6'h01;
                  end else begin
                     cnt_reg <= 6'h00;
                  end
               end
               MS_HDR: begin
                  sh_reg  <= wdata;
                  cnt_reg <= cnt_reg + 6'h01;
                  if (cnt_reg == HDR_LAST) begin
                     hdr_reg   <= laswc_hdr_t'(hdr_in);
                     state_reg <= MS_TA;
                     cnt_reg   <= 6'h00;
                  end
               end
               MS_TA: begin
                  cnt_reg <= cnt_reg + 6'h01;
                  if (cnt_reg != TA_LAST) begin
                     // second turnaround bit is driven low by the responder
                     oe_n_reg <= ~drive_rd;
                     drv_reg  <= 1'b0;
                  end else begin
                     state_reg <= MS_DATA;
                     cnt_reg   <= 6'h00;
                     sh_reg    <= rd_word;
                     drv_reg   <= drive_rd ? rd_word[15] : 1'b1;
                  end
               end
               MS_DATA: begin
                  cnt_reg <= cnt_reg + 6'h01;
                  if (drive_rd) begin
                     sh_reg  <= {sh_reg[14:0], 1'b0};
                     drv_reg <= sh_reg[14];
                  end else begin
                     sh_reg <= wdata;
                  end
                  if (cnt_reg == DATA_LAST) begin
                     state_reg <= MS_IDLE;
                     cnt_reg   <= 6'h00;
                     oe_n_reg  <= 1'b1;
                     drv_reg   <= 1'b1;
                  end
               end
               default: begin
                  state_reg <= MS_IDLE;
                  oe_n_reg  <= 1'b1;
               end
            endcase
         end
      end
   end

   // register writes
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         align_pos_reg <= RST_ALIGN_POS;
         align_neg_reg <= RST_ALIGN_NEG;
         auto_ctrl_reg <= RST_AUTO_CTRL;
         sw_on_reg     <= RST_SW_ON;
         sw_off_reg    <= RST_SW_OFF;
         sw_fill_reg   <= RST_SW_FILL;
         ext_addr_reg  <= RST_EXT_ADDR;
         addr_reg      <= RST_EXT_ADDR;
      end else begin
         if (wr_ptr) begin
            ext_addr_reg <= wdata;
         end
         if (wr_addr) begin
            addr_reg <= wdata;
         end else if (rd_inc) begin
            addr_reg <= addr_reg + 16'h0001;
         end
         if (wr_cfg) begin
            if (acc_addr == REG_ALIGN_POS) begin
               align_pos_reg <= wdata[9:0];
            end else if (acc_addr == REG_ALIGN_NEG) begin
               align_neg_reg <= wdata[9:0];
            end else if (acc_addr == REG_AUTO_CTRL) begin
               // bits 2:0 stored as written; the manager keeps them at 111
               auto_ctrl_reg <= wdata[6:0];
            end else if (acc_addr == REG_SW_ON) begin
               sw_on_reg <= wdata[9:0];
            end else if (acc_addr == REG_SW_OFF) begin
               sw_off_reg <= wdata[9:0];
            end else if (acc_addr == REG_SW_FILL) begin
               sw_fill_reg <= wdata[9:0];
            end
         end
      end
   end

   // alignment matching, health checks and clock squelch
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pos_hit_reg    <= 1'b0;
         neg_hit_reg    <= 1'b0;
         pll_fault_reg  <= 1'b0;
         loss_fault_reg <= 1'b0;
         sync_fault_reg <= 1'b0;
         clk_out_reg    <= 1'b0;
      end else begin
         pos_hit_reg    <= rx_valid_i && rx_char_i == align_pos_reg;
         neg_hit_reg    <= rx_valid_i && rx_char_i == align_neg_reg;
         pll_fault_reg  <= !auto_ctrl_reg[BIT_PLL_OFF] && !health_i.pll_locked;
         loss_fault_reg <= !auto_ctrl_reg[BIT_LOSS_OFF] && health_i.signal_loss;
         sync_fault_reg <= !auto_ctrl_reg[BIT_SYNC_OFF] && !health_i.sync_ok;
         clk_out_reg    <= (recovered_clock_output_is_recovered_i && auto_ctrl_reg[BIT_SQUELCH]
                            && health_i.signal_loss) ? 1'b0 : recovered_clock_i;
      end
   end

   assign align_pos_hit_o          = pos_hit_reg;
   assign align_neg_hit_o          = neg_hit_reg;
   assign pll_lock_fault_o         = pll_fault_reg;
   assign signal_loss_fault_o      = loss_fault_reg;
   assign sync_fault_o             = sync_fault_reg;
   assign recovered_clock_output_o = clk_out_reg;

   // transmit data switch
   wire f_ready  = ~tx_valid_reg | tx_ready_i;
   laswc_fifo #(
      .W     (CHAR_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .mclk_i      (mclk_i),
      .resetn_i    (resetn_i),
      .in_valid_i  (tx_valid_i),
      .in_data_i   (tx_char_i),
      .in_ready_o  (tx_ready_o),
      .out_valid_o (f_valid),
      .out_data_o  (f_data),
      .out_ready_i (f_ready)
   );

   wire take     = f_valid & f_ready;
   wire sw_mode  = mode_i == LASWC_MODE_10G || mode_i == LASWC_MODE_1GKX;
   wire on_hit   = sw_mode && f_data == sw_on_reg;
   wire off_hit  = sw_mode && f_data == sw_off_reg;
   wire off_next = !sw_mode ? 1'b0
                   : !take ? off_state_reg
                   : off_state_reg ? !on_hit : off_hit;
   wire do_fill  = mode_i == LASWC_MODE_10G && off_next;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         off_state_reg <= 1'b0;
         tx_valid_reg  <= 1'b0;
         tx_char_reg   <= 10'h000;
      end else begin
         off_state_reg <= off_next;
         if (take) begin
            tx_valid_reg <= 1'b1;
            tx_char_reg  <= do_fill ? sw_fill_reg : f_data;
         end else if (tx_ready_i) begin
            tx_valid_reg <= 1'b0;
         end
      end
   end

   assign tx_valid_o      = tx_valid_reg;
   assign tx_char_o       = tx_char_reg;
   assign tx_switch_off_o = off_state_reg;

   // checks
   a_align_pos_match: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      rx_valid_i && rx_char_i == align_pos_reg |=> align_pos_hit_o)
      else $error("positive alignment match missed");
   a_align_neg_match: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      !rx_valid_i || rx_char_i != align_neg_reg |=> !align_neg_hit_o)
      else $error("negative alignment hit without match");
   a_reserved_read_zero: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      state_reg == MS_TA && mdc_rise && cnt_reg == TA_LAST && !c22_ptr
      && (acc_addr == REG_ALIGN_POS || acc_addr == REG_ALIGN_NEG || acc_addr == REG_SW_ON
          || acc_addr == REG_SW_OFF || acc_addr == REG_SW_FILL)
      |=> sh_reg[15:10] == 6'h00)
      else $error("reserved character bits not zero");
   a_pll_check_off: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      auto_ctrl_reg[BIT_PLL_OFF] ##1 auto_ctrl_reg[BIT_PLL_OFF] |-> !pll_lock_fault_o)
      else $error("pll lock fault while check disabled");
   a_loss_check_on: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      !auto_ctrl_reg[BIT_LOSS_OFF] && health_i.signal_loss |=> signal_loss_fault_o)
      else $error("signal loss fault not reported");
   a_sync_check_off: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      auto_ctrl_reg[BIT_SYNC_OFF] && !health_i.sync_ok |=> !sync_fault_o)
      else $error("sync fault while check disabled");
   a_clock_squelch: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      recovered_clock_output_is_recovered_i && auto_ctrl_reg[BIT_SQUELCH] && health_i.signal_loss
      |=> !recovered_clock_output_o)
      else $error("recovered clock not flat during loss");
   a_switch_on_off: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      take && sw_mode && (off_state_reg ? on_hit : off_hit) |=> $changed(off_state_reg))
      else $error("switch state did not follow pattern match");
   a_fill_in_10g: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      take && mode_i == LASWC_MODE_10G && off_state_reg && !on_hit
      |=> tx_valid_o && tx_char_o == $past(sw_fill_reg))
      else $error("fill pattern not sent while switched off");
   a_pass_general: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      take && mode_i == LASWC_MODE_GENERAL |=> tx_char_o == $past(f_data) && !tx_switch_off_o)
      else $error("data altered outside switch modes");
   a_ext_pointer: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      wr_ptr |=> ext_addr_reg == $past(wdata))
      else $error("indirect address pointer not written");
endmodule : laswc_core

// [core/laswc_fifo.sv]
// character fifo with registered read data
`timescale 1ns/1ps
module laswc_fifo #(
   parameter int W     = 10,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic         mclk_i,
   input  wire logic         resetn_i,
   // fill side
   input  wire logic         in_valid_i,
   input  wire logic [W-1:0] in_data_i,
   output logic              in_ready_o,
   // drain side
   output logic              out_valid_o,
   output logic [W-1:0]      out_data_o,
   input  wire logic         out_ready_i
);
   // depth must be a power of two so pointers wrap naturally
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wptr_reg;
   logic [AW-1:0] rptr_reg;
   logic [AW:0]   cnt_reg;
   logic [W-1:0]  dout_reg;
   logic          dval_reg;

   wire push = in_valid_i & in_ready_o;
   wire pop  = (cnt_reg != '0) & (~dval_reg | out_ready_i);

   assign in_ready_o  = cnt_reg != (AW+1)'(DEPTH);
   assign out_valid_o = dval_reg;
   assign out_data_o  = dout_reg;

   always_ff @(posedge mclk_i) begin
      if (push) begin
         mem[wptr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         cnt_reg  <= '0;
         dout_reg <= '0;
         dval_reg <= 1'b0;
      end else begin
         if (push) begin
            wptr_reg <= wptr_reg + 1'b1;
         end
         if (pop) begin
            rptr_reg <= rptr_reg + 1'b1;
            dout_reg <= mem[rptr_reg];
            dval_reg <= 1'b1;
         end else if (out_ready_i) begin
            dval_reg <= 1'b0;
         end
         if (push && !pop) begin
            cnt_reg <= cnt_reg + 1'b1;
         end else if (pop && !push) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end
endmodule : laswc_fifo

// [dv/laswc_mgmt_model.sv]
// management station model for the serial management port
`timescale 1ns/1ps
module laswc_mgmt_model
   import laswc_pkg::*;
(
   // clock and device side of the line
   input  wire logic mclk_i,
   input  wire logic dev_mdio_i,
   input  wire logic dev_oe_n_i,
   // management clock and resolved line
   output logic      mdc_o,
   output logic      mdio_line_o
);
   logic drv_en  = 1'b1;
   logic drv_val = 1'b1;
   // a released line floats high on its pull-up
   assign mdio_line_o = !dev_oe_n_i ? dev_mdio_i : (drv_en ? drv_val : 1'b1);
   initial mdc_o = 1'b0;
   // one management clock: two mclk low, two high; the line is read as mdc rises
   task automatic bit_cycle(input logic en, input logic val, output logic seen);
      @(posedge mclk_i) #1;
      drv_en  = en;
      drv_val = val;
      mdc_o   = 1'b0;
      repeat (2) @(posedge mclk_i);
      #1;
      seen  = mdio_line_o;
      mdc_o = 1'b1;
      @(posedge mclk_i) #1;
   endtask : bit_cycle
   // full frame; on reads the station lets go of the line from turnaround on
   task automatic xfer(input logic [1:0] st, input logic [1:0] op, input logic [4:0] prt,
                       input logic [4:0] dev, input logic [15:0] wd, output logic [15:0] rd);
      logic [31:0] word;
      logic        rdop;
      logic        seen;
      word = {st, op, prt, dev, 2'b10, wd};
      rdop = (st == ST_C45) ? op[1] : (op == OP_C22_READ);
      rd   = 16'h0000;
      for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, seen);
      for (int i = 31; i >= 0; i--) begin
         bit_cycle(!(rdop && i < 18), word[i], seen);
         rd = {rd[14:0], seen};
      end
   endtask : xfer
endmodule : laswc_mgmt_model

// [dv/test_lane_align_data_switch_ctrl.sv]
// self-checking bench for the lane alignment and data switch control block
`timescale 1ns/1ps
module test_lane_align_data_switch_ctrl;
   import laswc_pkg::*;
   localparam logic [4:0] PRT = 5'h05;
   logic          mclk_i, mdc, mdio, mdo, mdo_oe_n, pos_hit, neg_hit, rc_prev, rc_out;
   logic          pll_f, loss_f, sync_f, tx_rdy, out_valid, sw_off;
   logic          resetn_i = 1'b0, rx_valid = 1'b0, rc = 1'b0, clk_sel = 1'b1;
   logic          tx_valid = 1'b0, out_rdy = 1'b1;
   logic [9:0]    rx_char = 10'h000, tx_char = 10'h000, out_char;
   logic [15:0]   r;
   logic [9:0]    got[$];
   laswc_mode_t   mode = LASWC_MODE_10G;
   laswc_health_t health = 3'b101;
   int            err_total = 0, comparisons = 0, cycles = 0;

   laswc_core dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .mdc_i(mdc), .mdio_i(mdio),
      .mdio_o(mdo), .mdio_oe_n_o(mdo_oe_n), .prtad_i(PRT), .mode_i(mode),
      .rx_valid_i(rx_valid), .rx_char_i(rx_char), .align_pos_hit_o(pos_hit),
      .align_neg_hit_o(neg_hit), .health_i(health), .pll_lock_fault_o(pll_f),
      .signal_loss_fault_o(loss_f), .sync_fault_o(sync_f), .recovered_clock_i(rc),
      .recovered_clock_output_is_recovered_i(clk_sel), .recovered_clock_output_o(rc_out),
      .tx_valid_i(tx_valid), .tx_char_i(tx_char), .tx_ready_o(tx_rdy), .tx_valid_o(out_valid),
      .tx_char_o(out_char), .tx_ready_i(out_rdy), .tx_switch_off_o(sw_off));
   laswc_mgmt_model mg (.mclk_i(mclk_i), .dev_mdio_i(mdo), .dev_oe_n_i(mdo_oe_n), .mdc_o(mdc),
      .mdio_line_o(mdio));

   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      rc_prev <= rc;
      #1 rc = ~rc;
   end
   always @(posedge mclk_i) begin
      if (out_valid === 1'b1 && out_rdy === 1'b1) got.push_back(out_char);
      cycles++;
      if (cycles == 80000) begin
         err_total++;
         summarize();
      end
   end

   task automatic tick();
      @(posedge mclk_i) #1;
   endtask : tick
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      mg.xfer(ST_C45, OP_C45_ADDR, PRT, MMD_DEVAD, a, r);
      mg.xfer(ST_C45, OP_C45_WRITE, PRT, MMD_DEVAD, d, r);
   endtask : wr
   task automatic rdc(input logic [15:0] a, input logic [15:0] e);
      mg.xfer(ST_C45, OP_C45_ADDR, PRT, MMD_DEVAD, a, r);
      mg.xfer(ST_C45, 2'h3, PRT, MMD_DEVAD, 16'h0000, r);
      chk(r, e);
   endtask : rdc
   task automatic send(input logic [9:0] c);
      tx_valid = 1'b1;
      tx_char  = c;
      while (tx_rdy !== 1'b1) tick();
      tick();
   endtask : send
   task automatic t_reset();
      rdc(REG_ALIGN_POS, 16'h0283);
      rdc(REG_ALIGN_NEG, 16'h017C);
      rdc(REG_AUTO_CTRL, 16'h000F);
      rdc(REG_SW_ON, 16'h02FD);
      rdc(REG_SW_OFF, 16'h02FD);
      rdc(REG_SW_FILL, 16'h0207);
      rdc(16'h8005, 16'h0000);
   endtask : t_reset
   task automatic t_reserved();
      wr(REG_ALIGN_POS, 16'hFD55);
      rdc(REG_ALIGN_POS, 16'h0155);
      wr(REG_ALIGN_NEG, 16'hFEAA);
      rdc(REG_ALIGN_NEG, 16'h02AA);
   endtask : t_reserved
   task automatic t_align();
      tick();
      rx_valid = 1'b1;
      rx_char  = 10'h155;
      tick();
      chk({pos_hit, neg_hit}, 2'b10);
      rx_char = 10'h2AA;
      tick();
      chk({pos_hit, neg_hit}, 2'b01);
      rx_valid = 1'b0;
      rx_char  = 10'h155;
      tick();
      chk({pos_hit, neg_hit}, 2'b00);
   endtask : t_align
   task automatic t_health();
      health = 3'b010;
      repeat (2) tick();
      chk({pll_f, loss_f, sync_f}, 3'b111);
      for (int i = 0; i < 3; i++) begin
         wr(REG_AUTO_CTRL, 16'h000F | (16'h0040 >> i));
         repeat (2) tick();
         chk({pll_f, loss_f, sync_f}, 3'b111 ^ (3'b100 >> i));
      end
      wr(REG_AUTO_CTRL, 16'hFF8F);
      rdc(REG_AUTO_CTRL, 16'h000F);
   endtask : t_health
   task automatic sq_chk(input logic flat);
      tick();
      repeat (4) begin
         tick();
         chk(rc_out, flat ? 1'b0 : rc_prev);
      end
   endtask : sq_chk
   task automatic t_squelch();
      sq_chk(1'b1);
      wr(REG_AUTO_CTRL, 16'h0007);
      sq_chk(1'b0);
      wr(REG_AUTO_CTRL, 16'h000F);
      clk_sel = 1'b0;
      sq_chk(1'b0);
      clk_sel = 1'b1;
      health  = 3'b101;
      sq_chk(1'b0);
   endtask : t_squelch
   task automatic t_switch();
      logic [9:0] seq[7];
      logic [9:0] exp[7];
      seq = '{10'h011, 10'h00F, 10'h022, 10'h00F, 10'h0F0, 10'h0F0, 10'h033};
      exp = '{10'h011, 10'h155, 10'h155, 10'h155, 10'h0F0, 10'h0F0, 10'h033};
      wr(REG_SW_ON, 16'h00F0);
      wr(REG_SW_OFF, 16'h000F);
      wr(REG_SW_FILL, 16'h0155);
      got.delete();
      tick();
      foreach (seq[i]) send(seq[i]);
      tx_valid = 1'b0;
      repeat (8) tick();
      chk(16'(got.size()), 16'd7);
      foreach (exp[i]) chk(got[i], exp[i]);
      mode = LASWC_MODE_1GKX;
      got.delete();
      send(10'h00F);
      tx_valid = 1'b0;
      repeat (6) tick();
      chk(sw_off, 1'b1);
      send(10'h044);
      send(10'h0F0);
      tx_valid = 1'b0;
      repeat (6) tick();
      chk(sw_off, 1'b0);
      chk(got[1], 10'h044);
      mode = LASWC_MODE_GENERAL;
      send(10'h00F);
      tx_valid = 1'b0;
      repeat (6) tick();
      chk(sw_off, 1'b0);
   endtask : t_switch
   task automatic t_full();
      int n;
      n = 0;
      got.delete();
      out_rdy  = 1'b0;
      tx_valid = 1'b1;
      while (tx_rdy === 1'b1 && n < 16) begin
         tx_char = 10'h100 + 10'(n);
         tick();
         n++;
      end
      tx_valid = 1'b0;
      chk(16'(n >= 8 && n <= 10), 16'd1);
      repeat (4) tick();
      chk(tx_rdy, 1'b0);
      out_rdy = 1'b1;
      repeat (20) tick();
      chk(16'(got.size()), 16'(n));
      foreach (got[i]) chk(got[i], 10'h100 + 10'(i));
   endtask : t_full
   task automatic t_indirect();
      mg.xfer(ST_C22, OP_C22_WRITE, PRT, C22_EXT_ADDR, REG_SW_FILL, r);
      mg.xfer(ST_C22, OP_C22_WRITE, PRT, C22_EXT_DATA, 16'hFE3C, r);
      mg.xfer(ST_C22, OP_C22_READ, PRT, C22_EXT_DATA, 16'h0000, r);
      chk(r, 16'h023C);
      mg.xfer(ST_C45, OP_C45_ADDR, PRT ^ 5'h01, MMD_DEVAD, REG_SW_FILL, r);
      mg.xfer(ST_C45, OP_C45_WRITE, PRT ^ 5'h01, MMD_DEVAD, 16'h0000, r);
      rdc(REG_SW_FILL, 16'h023C);
      mg.xfer(ST_C45, OP_C45_ADDR, PRT, MMD_DEVAD, REG_SW_ON, r);
      mg.xfer(ST_C45, OP_C45_RDINC, PRT, MMD_DEVAD, 16'h0000, r);
      chk(r, 16'h00F0);
      mg.xfer(ST_C45, OP_C45_RDINC, PRT, MMD_DEVAD, 16'h0000, r);
      chk(r, 16'h000F);
   endtask : t_indirect
   task automatic summarize();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (3) @(posedge mclk_i);
      #1;
      resetn_i = 1'b1;
      t_reset();
      t_reserved();
      t_align();
      t_health();
      t_squelch();
      t_switch();
      t_full();
      t_indirect();
      summarize();
   end
endmodule : test_lane_align_data_switch_ctrl
